// *** rtl/ans_status.sv ***
// Negotiation resolution status view with shared-address select and latched-high flags
//
// Operation
// - Select bit clear shows seed register; set shows resolution status register.
// - Gigabit suppression flag one: advertise no gigabit half or full duplex.
// - Gigabit suppression flag zero: advertise gigabit per gigabit control contents.
// - 100TX suppression flag one: advertise no 100TX half or full duplex.
// - 100TX suppression flag zero: advertise 100TX per advertisement register.
// - Speed downgrade sets a latched flag, held until the next read.
// - Gigabit full duplex resolution latches a flag until next read.
// - Gigabit half duplex resolution latches a flag until next read.
// - 100TX full duplex resolution latches a flag until next read.
// - 100TX half duplex resolution latches a flag until next read.
// - Gigabit full resolved without link latches a separate flag until read.
// - Gigabit half resolved without link latches a separate flag until read.
// - 100TX full resolved without link latches a separate flag until read.
// - 100TX half resolved without link latches a separate flag until read.
// - Negotiation disabled or restarted clears all flags in bits 12 to 0.
`timescale 1ns/1ns
`default_nettype none
`include "ans_defs.svh"

module ans_status (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic mgmtWrEn,
    input wire logic mgmtRdEn,
    input wire logic [4:0] mgmtDevAddr,
    input wire logic [15:0] mgmtRegAddr,
    input wire logic [15:0] mgmtWrData,
    output logic [15:0] mgmtRdData_ff,
    output logic mgmtRdValid_ff,
    output logic viewStatus_ff,
    input wire logic [14:0] seedViewData,
    output logic seedWrEn_ff,
    output logic [14:0] seedWrData_ff,
    input wire logic gigSuppress,
    input wire logic txSuppress,
    input wire ans_pkg::ans_evt_s negEvt,
    input wire logic anEnable,
    input wire logic anRestart,
    input wire logic [1:0] gigAbility,
    input wire logic [1:0] txAbility,
    output ans_pkg::ans_adv_s advOut_ff
);

    // Set beats clear so an event landing on the clearing read is kept
    function automatic logic latchNext(
        input logic cur,
        input logic setEvt,
        input logic clrEvt
    );
        latchNext = setEvt | (cur & ~clrEvt);
    endfunction

    function automatic logic addrHit(
        input logic [4:0] devAddr,
        input logic [15:0] regAddr
    );
        addrHit = (devAddr == `ANS_DEVICE_ADDR) && (regAddr == `ANS_REG_ADDR);
    endfunction

    // Access decode
    logic hit;
    logic rdHit;
    logic wrHit;
    ans_pkg::ans_view_e curView;
    ans_pkg::ans_view_e wrView;

    always_comb begin
        hit = addrHit(mgmtDevAddr, mgmtRegAddr);
        rdHit = hit & mgmtRdEn;
        wrHit = hit & mgmtWrEn;
        curView = viewStatus_ff ? ans_pkg::ANS_VIEW_STATUS : ans_pkg::ANS_VIEW_SEED;
        // A write is aimed by the select bit it carries
        wrView = mgmtWrData[`ANS_BIT_SELECT] ? ans_pkg::ANS_VIEW_STATUS : ans_pkg::ANS_VIEW_SEED;
    end

    // Configuration group: select bit, reserved bits, seed write hand-off
    logic [1:0] rsvHi_ff;
    logic [1:0] rsvLo_ff;
    logic nxt_viewStatus;
    logic [1:0] nxt_rsvHi;
    logic [1:0] nxt_rsvLo;
    logic nxt_seedWrEn;
    logic [14:0] nxt_seedWrData;

    always_comb begin
        nxt_viewStatus = viewStatus_ff;
        nxt_rsvHi = rsvHi_ff;
        nxt_rsvLo = rsvLo_ff;
        nxt_seedWrEn = 1'b0;
        nxt_seedWrData = seedWrData_ff;
        if (wrHit) begin
            // The select bit is common to both views
            nxt_viewStatus = mgmtWrData[`ANS_BIT_SELECT];
            unique case (wrView)
                ans_pkg::ANS_VIEW_STATUS: begin
                    // Only the select and reserved bits take a write here; flags are read-only
                    nxt_rsvHi = mgmtWrData[`ANS_LSB_RSV_HI +: 2];
                    nxt_rsvLo = mgmtWrData[`ANS_LSB_RSV_LO +: 2];
                end
                ans_pkg::ANS_VIEW_SEED: begin
                    nxt_seedWrEn = 1'b1;
                    nxt_seedWrData = mgmtWrData[14:0];
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            viewStatus_ff <= `ANS_RST_SELECT;
            rsvHi_ff <= `ANS_RST_RSV;
            rsvLo_ff <= `ANS_RST_RSV;
            seedWrEn_ff <= 1'b0;
            seedWrData_ff <= 15'h0000;
        end else begin
            viewStatus_ff <= nxt_viewStatus;
            rsvHi_ff <= nxt_rsvHi;
            rsvLo_ff <= nxt_rsvLo;
            seedWrEn_ff <= nxt_seedWrEn;
            seedWrData_ff <= nxt_seedWrData;
        end
    end

    // Suppression group: read-only mirrors of the downgrade machine
    logic gigSup_ff;
    logic txSup_ff;
    logic nxt_gigSup;
    logic nxt_txSup;

    always_comb begin
        nxt_gigSup = gigSuppress;
        nxt_txSup = txSuppress;
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            gigSup_ff <= `ANS_RST_SUPPRESS;
            txSup_ff <= `ANS_RST_SUPPRESS;
        end else begin
            gigSup_ff <= nxt_gigSup;
            txSup_ff <= nxt_txSup;
        end
    end

    // Advertisement group, taken from the same inputs as the mirrors so both move together
    ans_pkg::ans_adv_s nxt_adv;

    always_comb begin
        nxt_adv.gigFdx = gigAbility[1] & ~gigSuppress;
        nxt_adv.gigHdx = gigAbility[0] & ~gigSuppress;
        nxt_adv.txFdx = txAbility[1] & ~txSuppress;
        nxt_adv.txHdx = txAbility[0] & ~txSuppress;
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            advOut_ff <= '0;
        end else begin
            advOut_ff <= nxt_adv;
        end
    end

    // Latched-high group
    logic downgrade_ff;
    ans_pkg::ans_mode_t resolved_ff;
    ans_pkg::ans_mode_t noLink_ff;
    logic nxt_downgrade;
    ans_pkg::ans_mode_t nxt_resolved;
    ans_pkg::ans_mode_t nxt_noLink;
    logic clrRead;
    logic clrNeg;

    always_comb begin
        // Only a read of the status view consumes the flags
        clrRead = rdHit && (curView == ans_pkg::ANS_VIEW_STATUS);
        // Held clear while negotiation is off, so nothing latches until it is back on
        clrNeg = ~anEnable | anRestart;
        nxt_downgrade = latchNext(downgrade_ff, negEvt.downgrade, clrRead);
        for (int i = 0; i < 4; i++) begin
            nxt_resolved[i] = latchNext(resolved_ff[i], negEvt.resolved[i], clrRead);
            nxt_noLink[i] = latchNext(noLink_ff[i], negEvt.noLink[i], clrRead);
        end
        if (clrNeg) begin
            nxt_downgrade = 1'b0;
            nxt_resolved = `ANS_RST_LATCHED;
            nxt_noLink = `ANS_RST_LATCHED;
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            downgrade_ff <= 1'b0;
            resolved_ff <= `ANS_RST_LATCHED;
            noLink_ff <= `ANS_RST_LATCHED;
        end else begin
            downgrade_ff <= nxt_downgrade;
            resolved_ff <= nxt_resolved;
            noLink_ff <= nxt_noLink;
        end
    end

    // Read-back group: values are those before any clear caused by this same read
    logic [15:0] statusWord;
    logic [15:0] nxt_rdData;
    logic nxt_rdValid;

    always_comb begin
        statusWord = `ANS_RST_DATA;
        statusWord[`ANS_BIT_SELECT] = viewStatus_ff;
        statusWord[`ANS_BIT_GIG_SUPPRESS] = gigSup_ff;
        statusWord[`ANS_BIT_TX_SUPPRESS] = txSup_ff;
        statusWord[`ANS_BIT_DOWNGRADE] = downgrade_ff;
        statusWord[`ANS_LSB_RESOLVED +: 4] = resolved_ff;
        statusWord[`ANS_LSB_RSV_HI +: 2] = rsvHi_ff;
        statusWord[`ANS_LSB_NO_LINK +: 4] = noLink_ff;
        statusWord[`ANS_LSB_RSV_LO +: 2] = rsvLo_ff;
        nxt_rdValid = mgmtRdEn;
        // Unmatched addresses answer zero so a stray read never sees stale data
        nxt_rdData = `ANS_RST_DATA;
        if (rdHit) begin
            unique case (curView)
                ans_pkg::ANS_VIEW_STATUS: nxt_rdData = statusWord;
                ans_pkg::ANS_VIEW_SEED: nxt_rdData = {viewStatus_ff, seedViewData};
            endcase
        end
    end

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            mgmtRdData_ff <= `ANS_RST_DATA;
            mgmtRdValid_ff <= 1'b0;
        end else begin
            mgmtRdData_ff <= nxt_rdData;
            mgmtRdValid_ff <= nxt_rdValid;
        end
    end

endmodule

`default_nettype wire

// *** rtl/ans_defs.svh ***
// Offsets, field positions, reset values and decode constants of the resolution status view
`ifndef ANS_DEFS_SVH
`define ANS_DEFS_SVH

`define ANS_DEVICE_ADDR 5'h07
`define ANS_REG_ADDR 16'hFFFD

`define ANS_BIT_SELECT 15
`define ANS_BIT_GIG_SUPPRESS 14
`define ANS_BIT_TX_SUPPRESS 13
`define ANS_BIT_DOWNGRADE 12
`define ANS_LSB_RESOLVED 8
`define ANS_LSB_NO_LINK 2
`define ANS_LSB_RSV_HI 6
`define ANS_LSB_RSV_LO 0

`define ANS_RST_SELECT 1'h0
`define ANS_RST_SUPPRESS 1'h0
`define ANS_RST_LATCHED 4'h0
`define ANS_RST_RSV 2'h0
`define ANS_RST_DATA 16'h0000

`endif

// *** rtl/ans_pkg.sv ***
// Types shared by the resolution status view
`default_nettype none
package ans_pkg;

    // Mode vectors: [3] gigabit full, [2] gigabit half, [1] 100TX full, [0] 100TX half
    typedef logic [3:0] ans_mode_t;

    typedef struct packed {
        logic downgrade;
        ans_mode_t resolved;
        ans_mode_t noLink;
    } ans_evt_s;

    typedef struct packed {
        logic gigFdx;
        logic gigHdx;
        logic txFdx;
        logic txHdx;
    } ans_adv_s;

    typedef enum logic {
        ANS_VIEW_SEED,
        ANS_VIEW_STATUS
    } ans_view_e;

endpackage

`default_nettype wire

// *** testbench/ans_status_monitor.sv ***
// Port-level assertions for the resolution status view
`timescale 1ns/1ns
`default_nettype none
`include "ans_defs.svh"
module ans_status_monitor (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic mgmtWrEn,
    input wire logic mgmtRdEn,
    input wire logic [4:0] mgmtDevAddr,
    input wire logic [15:0] mgmtRegAddr,
    input wire logic [15:0] mgmtWrData,
    input wire logic [15:0] mgmtRdData_ff,
    input wire logic mgmtRdValid_ff,
    input wire logic viewStatus_ff,
    input wire logic [14:0] seedViewData,
    input wire logic seedWrEn_ff,
    input wire logic [14:0] seedWrData_ff,
    input wire logic gigSuppress,
    input wire logic txSuppress,
    input wire ans_pkg::ans_evt_s negEvt,
    input wire logic anEnable,
    input wire logic anRestart
);
    wire logic hit = mgmtDevAddr == `ANS_DEVICE_ADDR && mgmtRegAddr == `ANS_REG_ADDR;
    wire logic stRd = mgmtRdEn && hit && viewStatus_ff;
    wire logic neg = anEnable && !anRestart;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);
    a_read_valid: assert property (mgmtRdValid_ff == $past(mgmtRdEn)) else $error("bad valid");
    a_miss_zero: assert property (mgmtRdEn && !hit |=> mgmtRdData_ff == 16'h0000) else $error("miss data");
    a_seed_read: assert property (mgmtRdEn && hit && !viewStatus_ff |=>
        mgmtRdData_ff == {1'b0, $past(seedViewData)}) else $error("seed view data");
    a_status_top: assert property (stRd |=>
        mgmtRdData_ff[15:13] == {1'b1, $past(gigSuppress, 2), $past(txSuppress, 2)}) else $error("top bits");
    a_seed_write: assert property (mgmtWrEn && hit && !mgmtWrData[15] |=>
        seedWrEn_ff && !viewStatus_ff && {1'b0, seedWrData_ff} == ($past(mgmtWrData) & 16'h7fff))
        else $error("seed write");
    a_select_write: assert property (mgmtWrEn && hit && mgmtWrData[15] |=>
        viewStatus_ff && !seedWrEn_ff) else $error("select write");
    a_neg_clear: assert property (!neg ##1 stRd |=> (mgmtRdData_ff & 16'h1f3c) == 16'h0000)
        else $error("flags not cleared");
    // Flag set in a read cycle must survive that read
    a_set_wins: assert property ((stRd && neg && negEvt.resolved[3]) ##1 (neg && !mgmtRdEn && !mgmtWrEn)
        ##1 stRd |=> mgmtRdData_ff[11]) else $error("set lost");
endmodule
bind ans_status ans_status_monitor mon (.clk_sys, .reset, .mgmtWrEn, .mgmtRdEn, .mgmtDevAddr, .mgmtRegAddr,
    .mgmtWrData, .mgmtRdData_ff, .mgmtRdValid_ff, .viewStatus_ff, .seedViewData, .seedWrEn_ff, .seedWrData_ff,
    .gigSuppress, .txSuppress, .negEvt, .anEnable, .anRestart);
`default_nettype wire

// *** testbench/ans_mgr_model.sv ***
// Station manager model issuing accesses to the shared address
`timescale 1ns/1ns
`default_nettype none
`include "ans_defs.svh"
module ans_mgr_model (
    input wire logic clk_sys,
    output logic mgmtWrEn,
    output logic mgmtRdEn,
    output logic [4:0] mgmtDevAddr,
    output logic [15:0] mgmtRegAddr,
    output logic [15:0] mgmtWrData,
    input wire logic [15:0] mgmtRdData_ff,
    input wire logic mgmtRdValid_ff
);
    initial begin
        mgmtWrEn = 1'b0;
        mgmtRdEn = 1'b0;
        {mgmtDevAddr, mgmtRegAddr} = 21'h00_0000;
        mgmtWrData = 16'h0000;
    end
    task automatic acc(input logic wr, input logic [20:0] addr, input logic [15:0] d, output logic [15:0] q);
        @(posedge clk_sys);
        #1;
        mgmtWrEn = wr;
        mgmtRdEn = !wr;
        {mgmtDevAddr, mgmtRegAddr} = addr;
        mgmtWrData = d;
        @(posedge clk_sys);
        #1;
        q = mgmtRdValid_ff ? mgmtRdData_ff : 16'hxxxx;
        mgmtWrEn = 1'b0;
        mgmtRdEn = 1'b0;
        // Released lines carry the inverse so a stale copy cannot pass
        {mgmtDevAddr, mgmtRegAddr} = ~addr;
        mgmtWrData = ~d;
    endtask
    // Read-modify-write keeps the reserved bits when the status view is shown; from the seed view they take the seed bits
    task automatic sel(input logic on);
        logic [15:0] q;
        acc(1'b0, {`ANS_DEVICE_ADDR, `ANS_REG_ADDR}, 16'h0000, q);
        acc(1'b1, {`ANS_DEVICE_ADDR, `ANS_REG_ADDR}, {on, q[14:0]}, q);
    endtask
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// Self-checking bench for the resolution status view
`timescale 1ns/1ns
`default_nettype none
`include "ans_defs.svh"
module tb_top;
    localparam logic [20:0] ST = {`ANS_DEVICE_ADDR, `ANS_REG_ADDR};
    logic clk_sys = 1'b0;
    logic reset = 1'b1;
    logic mgmtWrEn, mgmtRdEn, mgmtRdValid_ff, viewStatus_ff, seedWrEn_ff;
    logic gigSuppress = 1'b0, txSuppress = 1'b0, anEnable = 1'b1, anRestart = 1'b0;
    logic [4:0] mgmtDevAddr;
    logic [15:0] mgmtRegAddr, mgmtWrData, mgmtRdData_ff, q;
    logic [14:0] seedWrData_ff;
    logic [14:0] seedViewData = 15'h1234;
    logic [1:0] gigAbility = 2'h0, txAbility = 2'h0;
    ans_pkg::ans_evt_s negEvt = '0;
    ans_pkg::ans_adv_s advOut_ff;
    int mismatches = 0, check_count = 0;
    always #25 clk_sys = ~clk_sys;
    ans_status dut (.clk_sys, .reset, .mgmtWrEn, .mgmtRdEn, .mgmtDevAddr, .mgmtRegAddr, .mgmtWrData,
        .mgmtRdData_ff, .mgmtRdValid_ff, .viewStatus_ff, .seedViewData, .seedWrEn_ff, .seedWrData_ff,
        .gigSuppress, .txSuppress, .negEvt, .anEnable, .anRestart, .gigAbility, .txAbility, .advOut_ff);
    ans_mgr_model mgr (.clk_sys, .mgmtWrEn, .mgmtRdEn, .mgmtDevAddr, .mgmtRegAddr, .mgmtWrData,
        .mgmtRdData_ff, .mgmtRdValid_ff);
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic rd(input logic [15:0] exp);
        mgr.acc(1'b0, ST, 16'h0000, q);
        chk(q, exp);
    endtask
    task automatic pulse(input ans_pkg::ans_evt_s e);
        @(posedge clk_sys);
        #1;
        negEvt = e;
        @(posedge clk_sys);
        #1;
        negEvt = '0;
    endtask
    function automatic logic [15:0] view(input ans_pkg::ans_evt_s e);
        return {3'b100, e.downgrade, e.resolved, 2'b00, e.noLink, 2'b00};
    endfunction
    initial begin
        #1_000_000;
        mismatches++;
        tally_and_finish();
    end
    initial begin
        int i;
        repeat (16) @(posedge clk_sys);
        #1;
        reset = 1'b0;
        rd(16'h1234);
        mgr.sel(1'b1);
        rd(16'h8000);
        for (i = 0; i < 9; i++) begin
            pulse(9'h001 << i);
            rd(view(9'h001 << i));
            rd(16'h8000);
        end
        // Event in the very cycle of a clearing read
        fork
            pulse(9'h080);
            rd(16'h8000);
        join
        rd(16'h8800);
        for (i = 0; i < 2; i++) begin
            pulse(9'h1ff);
            {anEnable, anRestart} = i ? 2'b11 : 2'b00;
            rd(16'h8000);
            {anEnable, anRestart} = 2'b10;
        end
        gigAbility = 2'h3;
        txAbility = 2'h3;
        for (i = 0; i < 2; i++) begin
            {gigSuppress, txSuppress} = i ? 2'b01 : 2'b10;
            repeat (2) @(posedge clk_sys);
            #1;
            chk({12'h000, advOut_ff}, i ? 16'h000c : 16'h0003);
            rd(i ? 16'ha000 : 16'hc000);
        end
        {gigSuppress, txSuppress} = 2'b00;
        // Read-only bits ignore writes, reserved bits are kept
        mgr.acc(1'b1, ST, 16'hffff, q);
        rd(16'h80c3);
        mgr.acc(1'b1, ST, 16'h8000, q);
        mgr.acc(1'b0, ST ^ 21'h00_0003, 16'h0000, q);
        chk(q, 16'h0000);
        mgr.sel(1'b0);
        rd(16'h1234);
        tally_and_finish();
    end
endmodule
`default_nettype wire
